// ### core/sar_conversion_control.v
// Control section and successive approximation register of the converter
`timescale 1ns/1ps
`include "sar_conv_defs.vh"
module sar_conversion_control #(
    parameter RES = `RES_FULL,
    parameter [`STEP_DIV_W-1:0] STEP_DIV = `INT_STEP_DIV
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Host command and options
    input wire convert,
    input wire ext_clk_sel,
    input wire ext_step,
    input wire [`RES_CNT_W-1:0] short_bits,
    input wire bipolar,
    input wire twos_comp,
    input wire serial_comp,
    // Comparator decision for the trial bit
    input wire cmp_keep,
    // Results
    output reg busy,
    output reg [RES-1:0] trial,
    output reg [RES-1:0] data_out,
    output reg serial_out,
    output reg bit_clk
);
    // Sequencer states
    localparam ST_IDLE = 2'h0;
    localparam ST_ARM = 2'h1;
    localparam ST_RUN = 2'h2;
    // Index of the last decision of a full-length conversion
    localparam [`RES_CNT_W-1:0] LAST_FULL = RES - 1;

    // Sequencer and search registers
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg conv_q;
    reg [RES-1:0] sar_q;
    reg [RES-1:0] sar_d;
    reg [`RES_CNT_W-1:0] idx_q;
    reg [`RES_CNT_W-1:0] idx_d;
    reg [`RES_CNT_W-1:0] last_q;
    reg [`RES_CNT_W-1:0] last_d;
    reg [`STEP_DIV_W-1:0] div_q;
    reg [`STEP_DIV_W-1:0] div_d;

    // Decoded events
    wire idle;
    wire arming;
    wire running;
    wire conv_rise;
    wire conv_fall;
    wire clear;
    wire start;
    wire int_step;
    wire step;
    wire last_step;

    // Word with the given MSB and every lower bit its inverse
    function [RES-1:0] edge_word;
        input msb;
        begin
            edge_word = {msb, {(RES-1){~msb}}};
        end
    endfunction

    // Bit position of a step index, counted from the MSB down
    function integer bit_pos;
        input [`RES_CNT_W-1:0] idx;
        begin
            bit_pos = RES - 1 - idx;
        end
    endfunction

    // Bits decided up to and including the given step
    function [RES-1:0] decided_mask;
        input [`RES_CNT_W-1:0] idx;
        begin
            decided_mask = ~({RES{1'b1}} >> (idx + 4'h1));
        end
    endfunction

    // Index of the last step; zero or an oversize count means full length
    function [`RES_CNT_W-1:0] last_index;
        input [`RES_CNT_W-1:0] n;
        begin
            if (n == {`RES_CNT_W{1'b0}} || n > RES)
                last_index = LAST_FULL;
            else
                last_index = n - 4'h1;
        end
    endfunction

    // Present the register with the selected parallel coding
    function [RES-1:0] code_out;
        input [RES-1:0] v;
        input bip;
        input tc;
        begin
            code_out = v;
            // Two's complement only makes sense for a bipolar range
            if (bip && tc)
                code_out[RES-1] = ~v[RES-1];
        end
    endfunction

    // Edges of the convert pulse
    assign conv_rise = convert & ~conv_q;
    assign conv_fall = ~convert & conv_q;
    assign idle = (state_q == ST_IDLE);
    assign arming = (state_q == ST_ARM);
    assign running = (state_q == ST_RUN);
    // Rises while busy and falls while idle fall through and are ignored
    assign clear = idle & conv_rise;
    assign start = arming & conv_fall; // RULE3

    // Internal divider gives the step rate; 62 cycles x 12 fits inside 3 us
    assign int_step = (div_q == STEP_DIV - 8'h01);
    // External steps are taken as they come, so the host owns their spacing
    assign step = running & (ext_clk_sel ? ext_step : int_step); // RULE11
    assign last_step = step & (idx_q == last_q);

    // Previous convert level for edge detection; idle level is low
    always @(posedge clk)
    begin
        if (rst)
        begin
            conv_q <= 1'b0;
        end
        else
        begin
            conv_q <= convert;
        end
    end

    // Divider restarts on every internal step and is held at zero outside a conversion
    always @*
    begin
        div_d = {`STEP_DIV_W{1'b0}};
        if (running && !int_step)
        begin
            div_d = div_q + 8'h01;
        end
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            div_q <= {`STEP_DIV_W{1'b0}};
        end
        else
        begin
            div_q <= div_d;
        end
    end

    // Sequencer: idle, armed by the rising edge, running after the fall
    always @*
    begin
        state_d = state_q;
        idx_d = idx_q;
        last_d = last_q;
        sar_d = sar_q;
        case (state_q)
            ST_IDLE:
            begin
                if (conv_rise)
                begin
                    sar_d = edge_word(1'b0); // RULE15
                    state_d = ST_ARM;
                end
            end
            ST_ARM:
            begin
                if (conv_fall)
                begin
                    // Search begins on the trailing edge only
                    state_d = ST_RUN; // RULE3
                    idx_d = {`RES_CNT_W{1'b0}};
                    last_d = last_index(short_bits); // RULE11
                    sar_d = edge_word(1'b1); // RULE13
                end
            end
            ST_RUN:
            begin
                if (step)
                begin
                    // One decision per step, MSB down
                    sar_d[bit_pos(idx_q)] = cmp_keep; // RULE7
                    if (idx_q == last_q)
                    begin
                        state_d = ST_IDLE; // RULE13
                    end
                    else
                    begin
                        idx_d = idx_q + 4'h1;
                        // Next trial bit goes high for the comparator
                        sar_d[bit_pos(idx_q) - 1] = 1'b1;
                    end
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            idx_q <= {`RES_CNT_W{1'b0}};
            last_q <= {`RES_CNT_W{1'b0}};
            sar_q <= {RES{1'b0}};
        end
        else
        begin
            state_q <= state_d;
            idx_q <= idx_d;
            last_q <= last_d;
            sar_q <= sar_d;
        end
    end

    // Busy rises with the first trial and falls with the last decision
    always @(posedge clk)
    begin
        if (rst)
        begin
            busy <= 1'b0;
        end
        else if (start)
        begin
            busy <= 1'b1; // RULE4
        end
        else if (last_step)
        begin
            busy <= 1'b0; // RULE5 RULE6
        end
    end

    // Trial word feeds the comparator; it rests at zero between conversions
    always @(posedge clk)
    begin
        if (rst)
        begin
            trial <= {RES{1'b0}};
        end
        else if (state_d == ST_RUN)
        begin
            trial <= sar_d; // RULE13
        end
        else
        begin
            trial <= {RES{1'b0}};
        end
    end

    // Parallel result: undecided bits read zero during a short cycle
    always @(posedge clk)
    begin
        if (rst)
        begin
            data_out <= {RES{1'b0}};
        end
        else if (clear)
        begin
            data_out <= edge_word(1'b0); // RULE2 RULE15
        end
        else if (step) // RULE17
        begin
            // Each bit appears on the edge that decides it
            data_out <= code_out(sar_d, bipolar, twos_comp) &
                decided_mask(idx_q); // RULE8 RULE14
        end
        // No other branch: the result stands until the next rising edge
    end

    // Serial output repeats each decision in NRZ form
    always @(posedge clk)
    begin
        if (rst)
        begin
            serial_out <= 1'b0;
        end
        else if (clear)
        begin
            serial_out <= 1'b0;
        end
        else if (step)
        begin
            serial_out <= cmp_keep ^ serial_comp; // RULE9 RULE10
        end
    end

    // Bit clock pulses one cycle after each step; it is low when idle except in the cycle after the last step
    always @(posedge clk)
    begin
        if (rst)
        begin
            bit_clk <= 1'b0;
        end
        else
        begin
            bit_clk <= step; // RULE13
        end
    end
endmodule

// ### core/sar_conv_defs.vh
// Constants for the successive approximation conversion control block
// Summary of operation
// RULE1: Host holds convert high at least 200 ns before letting it fall.
// RULE2: Rising edge of convert clears the result outputs before any conversion.
// RULE3: Bit search starts on the falling, trailing edge of convert.
// RULE4: Busy flag stays high through the conversion, low when result complete.
// RULE5: Conversion time runs from convert fall to busy fall, within grade limit.
// RULE6: Fastest grade finishes full resolution within 3 us on internal clock.
// RULE7: Register resolves twelve or ten bits, one per step, MSB first.
// RULE8: Parallel output binary or offset binary; MSB inverted gives two's complement.
// RULE9: Serial NRZ output in binary or complementary binary for unipolar.
// RULE10: Bipolar serial output is offset binary or complement, one bit per step.
// RULE11: Early end for short cycle and external clock are both supported.
// RULE12: Host must not rely on serial output in late production parts.
// RULE13: On convert, enable bit clock, reset register; at end stop clock, flag low.
// RULE14: Each result bit becomes valid at the end of its own clock step.
// RULE15: Convert rising edge sets MSB to zero and all lower bits to one.
// RULE16: External clock at least 30 percent duty and 100 ns period.
// RULE17: Completed result holds unchanged until the next convert rising edge.
// RULE18: Host samples after busy falls and never converts while busy.
`ifndef SAR_CONV_DEFS_VH
`define SAR_CONV_DEFS_VH
`define CLK_PERIOD_PS 4000
`define CONV_MAX_NS 3000
`define CONV_MAX_CYC ((`CONV_MAX_NS * 1000) / `CLK_PERIOD_PS)
`define INT_STEP_DIV 62
`define STEP_DIV_W 8
`define RES_FULL 12
`define RES_CNT_W 4
`define CODE_BIPOLAR 1'b1
`endif

// ### verif/sar_conv_assertions.sv
// Timing and result checks at the conversion control ports
`timescale 1ns/1ps
module sar_conv_checker #(parameter RES = 12) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Watched ports
    input wire convert,
    input wire serial_comp,
    input wire cmp_keep,
    input wire busy,
    input wire [RES-1:0] trial,
    input wire [RES-1:0] data_out,
    input wire serial_out,
    input wire bit_clk
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_rise_clear:
    assert property ($rose(convert) && !busy |=> data_out == {1'b0, {(RES-1){1'b1}}}) else $error("no clear");
    chk_rise_idle:
    assert property ($rose(convert) && !busy |=> !busy) else $error("start on rise");
    chk_fall_start:
    assert property ($fell(convert) && !busy |=> busy && trial == {1'b1, {(RES-1){1'b0}}}) else $error("no start");
    chk_conv_time:
    assert property ($rose(busy) |-> ##[1:749] !busy) else $error("too slow");
    chk_end_step:
    assert property ($fell(busy) |-> bit_clk) else $error("early end");
    chk_clk_idle:
    assert property (!busy && !$fell(busy) |-> !bit_clk) else $error("clock when idle");
    chk_result_hold:
    assert property (!busy && !convert && !$fell(convert) |=> $stable(data_out)) else $error("result moved");
    chk_serial_bit:
    assert property (bit_clk |-> serial_out == ($past(cmp_keep) ^ serial_comp)) else $error("bad serial");
endmodule
bind sar_conversion_control sar_conv_checker #(.RES(RES)) i_chk (.clk(clk), .rst(rst),
    .convert(convert), .serial_comp(serial_comp), .cmp_keep(cmp_keep), .busy(busy),
    .trial(trial), .data_out(data_out), .serial_out(serial_out), .bit_clk(bit_clk));

// ### verif/sar_comparator_model.sv
// Comparator model of the analog side
`timescale 1ns/1ps
module sar_comparator_model (
    input wire [11:0] trial,
    input wire [11:0] level,
    output wire cmp_keep
);
    // Trial bit kept while the trial word stays at or under the input
    assign cmp_keep = trial <= level;
endmodule

// ### verif/testbench.sv
// Random and corner conversions checked against the held input level
`timescale 1ns/1ps
module testbench;
    reg clk = 0, rst = 1, convert = 0, ext_clk_sel = 0, ext_step = 0, bipolar = 0;
    reg twos_comp = 0, serial_comp = 0;
    reg [3:0] short_bits = 0;
    reg [11:0] level = 0;
    wire cmp_keep, busy, serial_out, bit_clk;
    wire [11:0] trial, data_out;
    integer errors = 0, comparisons = 0, sc = 0, i, w;
    always #2 clk = ~clk;
    sar_conversion_control i_dut (.clk(clk), .rst(rst), .convert(convert),
        .ext_clk_sel(ext_clk_sel), .ext_step(ext_step), .short_bits(short_bits),
        .bipolar(bipolar), .twos_comp(twos_comp), .serial_comp(serial_comp),
        .cmp_keep(cmp_keep), .busy(busy), .trial(trial), .data_out(data_out),
        .serial_out(serial_out), .bit_clk(bit_clk));
    sar_comparator_model i_cmp (.trial(trial), .level(level), .cmp_keep(cmp_keep));
    // External steps kept 100 ns apart
    always @(negedge clk)
    begin
        sc = (sc + 1) % 25;
        ext_step <= ext_clk_sel && busy && sc == 0;
    end
    // Serial bits checked against the held level, MSB first
    integer sb = 0;
    always @(negedge clk)
    begin
        if (convert)
            sb = 0;
        else if (bit_clk === 1'b1)
        begin
            check({11'h000, serial_out}, {11'h000, level[11 - sb] ^ serial_comp});
            sb = sb + 1;
        end
    end
    function [11:0] want(input [11:0] v, input [3:0] n, input b, input t);
        begin
            want = (v & ((n == 0 || n > 12) ? 12'hFFF : ~(12'hFFF >> n))) ^ {b & t, 11'h000};
        end
    endfunction
    task check(input [11:0] got, input [11:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp)
            begin
                errors = errors + 1;
                $display("ERROR %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task complete_run;
        begin
            if (errors == 0 && comparisons > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial
    begin
        w = $urandom(46860);
        repeat (5) @(negedge clk);
        rst = 0;
        for (i = 0; i < 40; i = i + 1)
        begin
            @(negedge clk);
            level = i == 0 ? 12'hFFF : i == 1 ? 12'h000 : $urandom;
            {ext_clk_sel, bipolar, twos_comp, serial_comp, short_bits} = $urandom;
            if (i == 2)
                short_bits = 4'h1;
            @(negedge clk) convert = 1;
            repeat (51) @(negedge clk);
            check(data_out, 12'h7FF);
            check({11'h000, busy}, 12'h000);
            convert = 0;
            @(negedge clk);
            check({11'h000, busy}, 12'h001);
            w = 0;
            while (busy === 1'b1 && w < 800)
            begin
                @(negedge clk);
                w = w + 1;
            end
            check(data_out, want(level, short_bits, bipolar, twos_comp));
        end
        complete_run;
    end
    initial
    begin
        #200000;
        errors = errors + 1;
        complete_run;
    end
endmodule
